//--- include/bir_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bir_link_if;
   logic apic_clk;
   logic [1:0] apic_dat_o;
   logic [1:0] apic_dat_oen;
   logic [1:0] apic_dat_i;
   logic [1:0] apic_rsp_o;
   logic [1:0] apic_rsp_oen;
   logic legacy_intr;
   logic nmi;
   logic system_mgmt_interrupt;
   logic ser_dev_o;
   logic ser_dev_oen;
   logic ser_slv_o;
   logic ser_slv_oen;
   logic serialized_irq_line;
   // Open-drain style resolution of the two-wire data and serial line
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         apic_dat_i[i] = (apic_dat_oen[i] | apic_dat_o[i]) & (apic_rsp_oen[i] | apic_rsp_o[i]);
      end
      serialized_irq_line = (ser_dev_oen | ser_dev_o) & (ser_slv_oen | ser_slv_o);
   end
   modport dev (
      output apic_clk, apic_dat_o, apic_dat_oen, legacy_intr, nmi, system_mgmt_interrupt,
      output ser_dev_o, ser_dev_oen,
      input apic_dat_i, serialized_irq_line
   );
   modport cpu (
      input apic_clk, apic_dat_i, legacy_intr, nmi, system_mgmt_interrupt,
      output apic_rsp_o, apic_rsp_oen, ser_slv_o, ser_slv_oen,
      input serialized_irq_line
   );
endinterface
`default_nettype wire

//--- include/bir_pkg.sv
package bir_pkg;
   // Cascade: secondary controller output enters primary level 2
   localparam int BIR_CASCADE_LEVEL = 2;
   localparam int BIR_NUM_ISA = 16;
   localparam int BIR_NUM_PCI = 8;
   localparam int BIR_NUM_PCIX = 8;
   localparam int BIR_NUM_SRC = BIR_NUM_ISA + BIR_NUM_PCI + BIR_NUM_PCIX;
   localparam int BIR_SRC_W = 5;
   localparam int BIR_NUM_PINS = 24;
   localparam int BIR_MSG_BITS = 8;
   // Serialized IRQ frame: start, channel slots, stop
   localparam int BIR_SER_SLOTS = 17;
   // Host holds the line released for the slave's sync and edge latency
   localparam logic [4:0] BIR_SER_LAST = 5'h16;
   localparam logic [4:0] BIR_SER_LAG = 5'h06;
   localparam logic [5:0] BIR_SER_END = 6'h17;
   // Link clock divider: last count of a half period of 5 sys_clk cycles
   localparam logic [2:0] BIR_LCLK_HALF = 3'h4;
   localparam logic [2:0] BIR_BIT_LAST = 3'h7;
   // Recommended ISA levels
   localparam int BIR_IRQ_RTC = 8;
   // PCI input letter indices A..H
   localparam int BIR_PCI_C = 2;
   localparam int BIR_PCI_E = 4;
   localparam int BIR_PCI_F = 5;
   localparam int BIR_PCI_G = 6;
   localparam int BIR_PCI_H = 7;
   typedef enum logic [1:0] {
      BIR_LK_IDLE = 2'b00,
      BIR_LK_SEND = 2'b01,
      BIR_LK_DONE = 2'b10
   } bir_link_e;
   typedef enum logic [1:0] {
      BIR_SQ_IDLE = 2'b00,
      BIR_SQ_START = 2'b01,
      BIR_SQ_SLOT = 2'b10,
      BIR_SQ_STOP = 2'b11
   } bir_ser_e;
endpackage

//--- logic/bir_cpu_end.sv
`timescale 1ns/1ns
`default_nettype none
module bir_cpu_end
   import bir_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   bir_link_if.cpu link,
   input wire logic ser_req,
   input wire logic [BIR_SER_SLOTS-1:0] ser_irq_drive,
   output logic msg_valid,
   output logic [BIR_MSG_BITS-1:0] msg_vector,
   output logic intr_seen,
   output logic nmi_seen,
   output logic smi_seen
);
   logic [2:0] clk_sync_reg;
   logic [1:0] d0_sync_reg;
   logic [1:0] d1_sync_reg;
   logic [1:0] ser_sync_reg;
   logic [1:0] lv0_reg;
   logic [1:0] lv1_reg;
   logic [1:0] lv2_reg;
   logic rise;
   logic [2:0] cnt_reg;
   logic active_reg;
   logic [BIR_MSG_BITS*2-1:0] sh_reg;
   logic valid_reg;
   logic [BIR_MSG_BITS-1:0] vec_reg;
   logic s_o_reg;
   logic s_oen_reg;
   logic [5:0] slot_reg;
   logic in_frame_reg;
   logic prev_ser_reg;
   logic req_sent_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clk_sync_reg <= 3'h0;
         d0_sync_reg <= 2'b11;
         d1_sync_reg <= 2'b11;
         ser_sync_reg <= 2'b11;
         lv0_reg <= 2'b00;
         lv1_reg <= 2'b00;
         lv2_reg <= 2'b00;
      end else begin
         clk_sync_reg <= {clk_sync_reg[1:0], link.apic_clk};
         d0_sync_reg <= {d0_sync_reg[0], link.apic_dat_i[0]};
         d1_sync_reg <= {d1_sync_reg[0], link.apic_dat_i[1]};
         ser_sync_reg <= {ser_sync_reg[0], link.serialized_irq_line};
         lv0_reg <= {lv0_reg[0], link.legacy_intr};
         lv1_reg <= {lv1_reg[0], link.nmi};
         lv2_reg <= {lv2_reg[0], link.system_mgmt_interrupt};
      end
   end
   assign rise = clk_sync_reg[1] & ~clk_sync_reg[2];

   // Sample two data wires on each link clock rise; start is first driven pair
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 3'h0;
         active_reg <= 1'b0;
         sh_reg <= '0;
         valid_reg <= 1'b0;
         vec_reg <= '0;
      end else begin
         valid_reg <= 1'b0;
         if (rise) begin // R07
            sh_reg <= {d1_sync_reg[1], d0_sync_reg[1], sh_reg[BIR_MSG_BITS*2-1:2]};
            if (active_reg) begin
               cnt_reg <= cnt_reg + 3'h1;
               if (cnt_reg == BIR_BIT_LAST) begin
                  active_reg <= 1'b0;
                  valid_reg <= 1'b1;
                  vec_reg <= {d1_sync_reg[1], d0_sync_reg[1], sh_reg[BIR_MSG_BITS*2-1:BIR_MSG_BITS+2]};
               end
            end
         end
         if (link.apic_rsp_oen == 2'b11 && !active_reg && rise && d0_sync_reg[1] == 1'b0) begin
            active_reg <= 1'b1;
            cnt_reg <= 3'h1;
         end
      end
   end

   // Serial IRQ slave: quiet-mode start request, drive slot low per request
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_o_reg <= 1'b1;
         s_oen_reg <= 1'b1;
         slot_reg <= 6'h00;
         in_frame_reg <= 1'b0;
         prev_ser_reg <= 1'b1;
         req_sent_reg <= 1'b0;
      end else begin
         prev_ser_reg <= ser_sync_reg[1];
         s_o_reg <= 1'b1;
         s_oen_reg <= 1'b1;
         if (!in_frame_reg) begin
            // Frame timing counts from the end of the last low cycle
            if (!prev_ser_reg && ser_sync_reg[1]) begin
               in_frame_reg <= 1'b1;
               req_sent_reg <= 1'b0;
               slot_reg <= 6'h00;
            end else if (ser_req && !req_sent_reg) begin // R12
               if (ser_sync_reg[1]) begin
                  s_o_reg <= 1'b0;
                  s_oen_reg <= 1'b0;
               end else begin
                  req_sent_reg <= 1'b1;
               end
            end
         end else begin
            slot_reg <= slot_reg + 6'h01;
            if (slot_reg < 6'(BIR_SER_SLOTS)) begin // R11
               s_o_reg <= ~ser_irq_drive[5'(slot_reg)];
               s_oen_reg <= ~ser_irq_drive[5'(slot_reg)];
            end
            if (slot_reg == BIR_SER_END) begin
               in_frame_reg <= 1'b0;
            end
         end
      end
   end
   assign link.ser_slv_o = s_o_reg;
   assign link.ser_slv_oen = s_oen_reg;
   assign link.apic_rsp_o = 2'b11;
   assign link.apic_rsp_oen = 2'b11;
   assign msg_valid = valid_reg;
   assign msg_vector = vec_reg;
   assign intr_seen = lv0_reg[1];
   assign nmi_seen = lv1_reg[1];
   assign smi_seen = lv2_reg[1];
endmodule
`default_nettype wire

//--- logic/bir_router.sv
// Function
// R01 - Two cascaded controllers, levels 8-15 into 2
// R02 - Legacy mode: one combined processor interrupt
// R03 - Programmable source select per APIC pin
// R04 - Slot INTA-D to F,G,E,H; NIC to C
// R05 - PCI-X slots map 0-3 and 5,6,7,4
// R06 - PCI and ISA inputs become bus messages
// R07 - APIC mode: messages over three-wire link
// R08 - Monitor all sources, above sixteen levels
// R09 - Recommended ISA level assignment, RTC active-low
// R10 - Separate system management interrupt output
// R11 - Serial frame: start, 17 slots, stop
// R12 - Quiet: slave starts; continuous: host starts
// R13 - Parity errors retried or reported as system error; no parity logic here, system error comes in on serr_n only
// R14 - System error to NMI only when enabled
// R15 - PCI inputs active-low, level, shareable
`timescale 1ns/1ns
`default_nettype none
module bir_router
   import bir_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   bir_link_if.dev link,
   input wire logic [BIR_NUM_ISA-1:0] isa_irq,
   input wire logic rtc_request_low,
   input wire logic [BIR_NUM_PCI-1:0] slot_int_n,
   input wire logic nic_int_n,
   input wire logic [3:0] pcix_slot1_int_n,
   input wire logic [3:0] pcix_slot2_int_n,
   input wire logic serr_n,
   input wire logic serr_nmi_en,
   input wire logic apic_mode,
   input wire logic ser_continuous,
   input wire logic smi_req,
   input wire logic [BIR_NUM_PINS*BIR_SRC_W-1:0] pin_src_sel,
   output logic [BIR_SER_SLOTS-1:0] ser_irq_seen,
   output logic busy
);
   logic [BIR_NUM_PCI-1:0] pci_irq_n;
   logic [BIR_NUM_PCIX-1:0] pcix_irq_n;
   logic [BIR_NUM_SRC-1:0] raw_src;
   logic [BIR_NUM_SRC-1:0] s1_reg;
   logic [BIR_NUM_SRC-1:0] src_reg;
   logic [1:0] serr_sync_reg;
   logic [1:0] ser_sync_reg;
   logic [BIR_NUM_ISA-1:0] isa_lvl;
   logic [BIR_NUM_PINS-1:0] pin_lvl;
   logic [BIR_NUM_PINS-1:0] pin_prev_reg;
   logic [BIR_NUM_PINS-1:0] pend_reg;
   logic intr_reg;
   logic nmi_reg;
   logic smi_reg;

   // Board wiring of slot pins onto PCI letters A..H
   always_comb begin
      pci_irq_n = '1;
      pci_irq_n[BIR_PCI_F] = slot_int_n[0]; // R04
      pci_irq_n[BIR_PCI_G] = slot_int_n[1]; // R04
      pci_irq_n[BIR_PCI_E] = slot_int_n[2]; // R04
      pci_irq_n[BIR_PCI_H] = slot_int_n[3]; // R04
      pci_irq_n[BIR_PCI_C] = nic_int_n; // R04
      pcix_irq_n[3:0] = pcix_slot1_int_n; // R05
      pcix_irq_n[7:5] = pcix_slot2_int_n[2:0]; // R05
      pcix_irq_n[4] = pcix_slot2_int_n[3]; // R05
   end

   // Active-low shared levels inverted, RTC request is low-true
   always_comb begin
      raw_src[BIR_NUM_ISA-1:0] = isa_irq;
      raw_src[BIR_IRQ_RTC] = ~rtc_request_low; // R09
      raw_src[BIR_NUM_ISA +: BIR_NUM_PCI] = ~pci_irq_n; // R15
      raw_src[BIR_NUM_ISA+BIR_NUM_PCI +: BIR_NUM_PCIX] = ~pcix_irq_n; // R15
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= '0;
         src_reg <= '0;
         serr_sync_reg <= 2'b00;
         ser_sync_reg <= 2'b11;
      end else begin
         s1_reg <= raw_src; // R08
         src_reg <= s1_reg;
         serr_sync_reg <= {serr_sync_reg[0], ~serr_n};
         ser_sync_reg <= {ser_sync_reg[0], link.serialized_irq_line};
      end
   end

   // Cascade: secondary any-level feeds primary level 2
   always_comb begin
      isa_lvl = src_reg[BIR_NUM_ISA-1:0];
      isa_lvl[BIR_CASCADE_LEVEL] = |src_reg[BIR_NUM_ISA-1:BIR_IRQ_RTC]; // R01
   end

   // Programmable source per APIC input pin
   genvar gp;
   generate
      for (gp = 0; gp < BIR_NUM_PINS; gp++) begin : g_pin
         assign pin_lvl[gp] = src_reg[pin_src_sel[gp*BIR_SRC_W +: BIR_SRC_W]]; // R03
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         intr_reg <= 1'b0;
         nmi_reg <= 1'b0;
         smi_reg <= 1'b0;
      end else begin
         intr_reg <= ~apic_mode & (|isa_lvl); // R02
         nmi_reg <= serr_sync_reg[1] & serr_nmi_en; // R14
         smi_reg <= smi_req; // R10
      end
   end
   assign link.legacy_intr = intr_reg;
   assign link.nmi = nmi_reg;
   assign link.system_mgmt_interrupt = smi_reg;

   // APIC message sender: 8-bit message, vector in low 5 bits, two bits per clock
   bir_link_e lk_reg;
   logic [2:0] div_reg;
   logic clk_reg;
   logic [2:0] bit_reg;
   logic [BIR_SRC_W-1:0] cur_reg;
   logic [BIR_MSG_BITS*2-1:0] shift_reg;
   logic [1:0] dat_reg;
   logic [1:0] oen_reg;
   logic found;
   logic [BIR_SRC_W-1:0] found_idx;
   logic [BIR_NUM_PINS-1:0] pend_next;
   logic fall;

   always_comb begin
      found = 1'b0;
      found_idx = '0;
      for (int i = BIR_NUM_PINS-1; i >= 0; i--) begin
         if (pend_reg[i]) begin
            found = 1'b1;
            found_idx = BIR_SRC_W'(i);
         end
      end
   end

   assign fall = (div_reg == BIR_LCLK_HALF) & clk_reg;

   // Rising level on a pin raises a pending message; set wins over clear
   always_comb begin
      pend_next = pend_reg;
      if (lk_reg == BIR_LK_IDLE && found && apic_mode) begin
         pend_next[found_idx] = 1'b0;
      end
      pend_next = pend_next | (pin_lvl & ~pin_prev_reg); // R06
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pin_prev_reg <= '0;
         pend_reg <= '0;
      end else begin
         pin_prev_reg <= pin_lvl;
         pend_reg <= pend_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 3'h0;
         clk_reg <= 1'b0;
      end else if (div_reg == BIR_LCLK_HALF) begin
         div_reg <= 3'h0;
         clk_reg <= ~clk_reg;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end
   assign link.apic_clk = clk_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lk_reg <= BIR_LK_IDLE;
         bit_reg <= 3'h0;
         cur_reg <= '0;
         shift_reg <= '0;
         dat_reg <= 2'b11;
         oen_reg <= 2'b11;
      end else begin
         unique case (lk_reg)
            BIR_LK_IDLE: begin
               if (found && apic_mode) begin
                  cur_reg <= found_idx;
                  // Low byte of zero pairs marks the start for the receiver
                  shift_reg <= {3'h0, found_idx, 8'h00};
                  bit_reg <= 3'h0;
                  lk_reg <= BIR_LK_SEND;
               end
            end
            BIR_LK_SEND: begin
               if (fall) begin // R07
                  dat_reg <= shift_reg[1:0];
                  oen_reg <= 2'b00;
                  shift_reg <= {2'b00, shift_reg[BIR_MSG_BITS*2-1:2]};
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == BIR_BIT_LAST) begin
                     lk_reg <= BIR_LK_DONE;
                  end
               end
            end
            BIR_LK_DONE: begin
               if (fall) begin
                  dat_reg <= 2'b11;
                  oen_reg <= 2'b11;
                  lk_reg <= BIR_LK_IDLE;
               end
            end
            default: lk_reg <= BIR_LK_IDLE;
         endcase
      end
   end
   assign link.apic_dat_o = dat_reg;
   assign link.apic_dat_oen = oen_reg;

   // Serialized IRQ host: start frame then 17 slots then stop
   bir_ser_e sq_reg;
   logic [4:0] slot_reg;
   logic ser_o_reg;
   logic ser_oen_reg;
   logic [BIR_SER_SLOTS-1:0] seen_reg;
   logic [1:0] quiet_hold_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sq_reg <= BIR_SQ_IDLE;
         quiet_hold_reg <= 2'b00;
         slot_reg <= 5'h00;
         ser_o_reg <= 1'b1;
         ser_oen_reg <= 1'b1;
         seen_reg <= '0;
      end else begin
         quiet_hold_reg <= {1'b0, quiet_hold_reg[1]};
         unique case (sq_reg)
            BIR_SQ_IDLE: begin
               // Continuous host starts; quiet mode a slave pulls low
               if (ser_continuous) begin // R12
                  ser_o_reg <= 1'b0;
                  ser_oen_reg <= 1'b0;
                  sq_reg <= BIR_SQ_START;
               end else if (!ser_sync_reg[1] && quiet_hold_reg == 2'b00) begin // R12
                  ser_o_reg <= 1'b0;
                  ser_oen_reg <= 1'b0;
                  sq_reg <= BIR_SQ_START;
               end
            end
            BIR_SQ_START: begin
               ser_o_reg <= 1'b1;
               ser_oen_reg <= 1'b1;
               slot_reg <= 5'h00;
               sq_reg <= BIR_SQ_SLOT;
            end
            BIR_SQ_SLOT: begin
               if (slot_reg >= BIR_SER_LAG) begin
                  seen_reg[slot_reg - BIR_SER_LAG] <= ~ser_sync_reg[1]; // R11
               end
               slot_reg <= slot_reg + 5'h01;
               if (slot_reg == BIR_SER_LAST) begin
                  ser_o_reg <= 1'b0;
                  ser_oen_reg <= 1'b0;
                  sq_reg <= BIR_SQ_STOP;
               end
            end
            BIR_SQ_STOP: begin
               // Own stop frame is still in the synchroniser: ignore it
               quiet_hold_reg <= 2'b11;
               ser_o_reg <= 1'b1;
               ser_oen_reg <= 1'b1;
               sq_reg <= BIR_SQ_IDLE;
            end
            default: sq_reg <= BIR_SQ_IDLE;
         endcase
      end
   end
   assign link.ser_dev_o = ser_o_reg;
   assign link.ser_dev_oen = ser_oen_reg;
   assign ser_irq_seen = seen_reg;
   assign busy = lk_reg != BIR_LK_IDLE;
endmodule
`default_nettype wire

//--- tb/bir_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module bir_monitor (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic apic_clk,
   input wire logic [1:0] apic_dat_o,
   input wire logic [1:0] apic_dat_oen,
   input wire logic legacy_intr,
   input wire logic ser_dev_o,
   input wire logic ser_dev_oen
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   logic [6:0] drv_cnt;
   logic ser_half;
   logic [4:0] ser_cnt;
   // Cycles the data pair has been driven so far
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         drv_cnt <= 7'h00;
      end else if (apic_dat_oen[0]) begin
         drv_cnt <= 7'h00;
      end else begin
         drv_cnt <= drv_cnt + 7'h01;
      end
   end
   // Pairs start and stop frames, counts released cycles between them
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ser_half <= 1'b0;
         ser_cnt <= 5'h00;
      end else if ($fell(ser_dev_oen)) begin
         ser_half <= !ser_half;
         ser_cnt <= 5'h00;
      end else if (ser_dev_oen) begin
         ser_cnt <= ser_cnt + 5'h01;
      end
   end
   sequence s_start;
      $fell(ser_dev_oen) && !ser_half;
   endsequence
   sequence s_stop;
      $fell(ser_dev_oen) && ser_half;
   endsequence
   property p_clk_high;
      $rose(apic_clk) |-> apic_clk [*5] ##1 !apic_clk;
   endproperty
   property p_clk_low;
      $fell(apic_clk) |-> !apic_clk [*5];
   endproperty
   property p_oen_pair;
      apic_dat_oen[0] == apic_dat_oen[1];
   endproperty
   property p_msg_len;
      $rose(apic_dat_oen[0]) |-> drv_cnt inside {[7'h4f:7'h51]};
   endproperty
   property p_msg_edge;
      $fell(apic_dat_oen[0]) |-> !apic_clk;
   endproperty
   property p_msg_mode;
      $fell(apic_dat_oen[0]) |-> !legacy_intr;
   endproperty
   property p_ser_low;
      !ser_dev_oen |-> !ser_dev_o;
   endproperty
   property p_ser_start;
      s_start |=> ser_dev_oen;
   endproperty
   property p_ser_frame;
      s_stop |-> ser_cnt == 5'h17 ##1 ser_dev_oen;
   endproperty
   a_clk_high: assert property (p_clk_high) else $error("link clock high phase wrong");
   a_clk_low: assert property (p_clk_low) else $error("link clock low phase short");
   a_oen_pair: assert property (p_oen_pair) else $error("data lines not driven together");
   a_msg_len: assert property (p_msg_len) else $error("message length wrong");
   a_msg_edge: assert property (p_msg_edge) else $error("message not started at clock fall");
   a_msg_mode: assert property (p_msg_mode) else $error("message sent in legacy mode");
   a_ser_low: assert property (p_ser_low) else $error("serial line driven high");
   a_ser_start: assert property (p_ser_start) else $error("start frame too long");
   a_ser_frame: assert property (p_ser_frame) else $error("slot count wrong");
endmodule
`default_nettype wire

//--- tb/board_interrupt_routing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module board_interrupt_routing_tb_top;
   import bir_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] isa_irq = 16'h0000;
   logic rtc_request_low = 1'b1;
   logic [7:0] slot_int_n = 8'hff;
   logic nic_int_n = 1'b1;
   logic [3:0] px1_n = 4'hf;
   logic [3:0] px2_n = 4'hf;
   logic serr_n = 1'b1;
   logic serr_nmi_en = 1'b0;
   logic apic_mode = 1'b0;
   logic ser_cont = 1'b0;
   logic smi_req = 1'b0;
   // Idle pins point at a PCI letter that nothing drives
   logic [BIR_NUM_PINS*BIR_SRC_W-1:0] sel = {BIR_NUM_PINS{5'h10}};
   logic ser_req = 1'b0;
   logic [16:0] ser_drv = 17'h0_0000;
   logic [16:0] ser_seen;
   logic busy, msg_valid, intr_seen, nmi_seen, smi_seen;
   logic [7:0] msg_vector;
   int n_fail = 0;
   int tests_run = 0;
   int seed = 32'h3a66_1d60;
   int exp_q[$];
   bir_link_if link ();
   bir_router i_bir_router (.sys_clk(sys_clk), .rstn(rstn), .link(link), .isa_irq(isa_irq),
      .rtc_request_low(rtc_request_low), .slot_int_n(slot_int_n), .nic_int_n(nic_int_n),
      .pcix_slot1_int_n(px1_n), .pcix_slot2_int_n(px2_n), .serr_n(serr_n),
      .serr_nmi_en(serr_nmi_en), .apic_mode(apic_mode), .ser_continuous(ser_cont),
      .smi_req(smi_req), .pin_src_sel(sel), .ser_irq_seen(ser_seen), .busy(busy));
   bir_cpu_end i_bir_cpu_end (.sys_clk(sys_clk), .rstn(rstn), .link(link), .ser_req(ser_req),
      .ser_irq_drive(ser_drv), .msg_valid(msg_valid), .msg_vector(msg_vector),
      .intr_seen(intr_seen), .nmi_seen(nmi_seen), .smi_seen(smi_seen));
   bir_monitor i_bir_monitor (.sys_clk(sys_clk), .rstn(rstn), .apic_clk(link.apic_clk),
      .apic_dat_o(link.apic_dat_o), .apic_dat_oen(link.apic_dat_oen),
      .legacy_intr(link.legacy_intr), .ser_dev_o(link.ser_dev_o),
      .ser_dev_oen(link.ser_dev_oen));
   always #10 sys_clk = ~sys_clk;
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Source index that each physical input should reach
   function automatic int src_of(input int id, input int isa);
      int slot_map[4] = '{BIR_PCI_F, BIR_PCI_G, BIR_PCI_E, BIR_PCI_H};
      int px2_map[4] = '{5, 6, 7, 4};
      if (id < 4) return 16 + slot_map[id];
      if (id == 4) return 16 + BIR_PCI_C;
      if (id < 9) return 24 + id - 5;
      if (id < 13) return 24 + px2_map[id-9];
      if (id == 13) return BIR_IRQ_RTC;
      return isa;
   endfunction
   task automatic drive_in(input int id, input int isa, input logic on);
      @(posedge sys_clk);
      case (id) inside
         [0:3]: slot_int_n[id] <= !on;
         4: nic_int_n <= !on;
         [5:8]: px1_n[id-5] <= !on;
         [9:12]: px2_n[id-9] <= !on;
         13: rtc_request_low <= !on;
         default: isa_irq[isa] <= on;
      endcase
   endtask
   always @(posedge sys_clk) begin
      if (msg_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("msg_extra", 32'h0, 32'h1);
         end else begin
            chk("msg_vector", exp_q.pop_front(), {24'h0, msg_vector});
         end
      end
   end
   task automatic apic_one(input int id, input int pin);
      int isa;
      int k;
      isa = 9 + ($random(seed) & 32'h7fff_ffff) % 7;
      @(posedge sys_clk);
      sel[pin*BIR_SRC_W +: BIR_SRC_W] <= 5'(src_of(id, isa));
      repeat (4) @(posedge sys_clk);
      exp_q.push_back(pin);
      drive_in(id, isa, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk("msg_held", 32'h1, exp_q.size());
      apic_mode <= 1'b1;
      k = 0;
      while (exp_q.size() != 0 && k < 400) begin
         @(posedge sys_clk);
         k++;
      end
      chk("msg_wait", 32'h0, exp_q.size());
      chk("intr_apic", 32'h0, intr_seen);
      drive_in(id, isa, 1'b0);
      repeat (10) @(posedge sys_clk);
      sel[pin*BIR_SRC_W +: BIR_SRC_W] <= 5'h10;
      apic_mode <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask
   initial begin
      int k;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 16; i++) begin
         drive_in(i == 8 ? 13 : 14, i, 1'b1);
         repeat (12) @(posedge sys_clk);
         chk("intr_on", (i != BIR_CASCADE_LEVEL), intr_seen);
         drive_in(i == 8 ? 13 : 14, i, 1'b0);
         repeat (12) @(posedge sys_clk);
         chk("intr_off", 32'h0, intr_seen);
      end
      for (int en = 0; en < 2; en++) begin
         serr_nmi_en <= en[0];
         serr_n <= 1'b0;
         repeat (12) @(posedge sys_clk);
         chk("nmi_on", en, nmi_seen);
         serr_n <= 1'b1;
         repeat (12) @(posedge sys_clk);
         chk("nmi_off", 32'h0, nmi_seen);
      end
      smi_req <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("smi_on", 32'h1, smi_seen);
      smi_req <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk("smi_off", 32'h0, smi_seen);
      for (int id = 14; id >= 0; id--) begin
         apic_one(id, ($random(seed) & 32'h7fff_ffff) % BIR_NUM_PINS);
      end
      for (int m = 0; m < 4; m++) begin
         ser_cont <= !m[1];
         ser_req <= m[1];
         ser_drv <= 17'($random(seed));
         @(posedge sys_clk);
         k = 0;
         while (ser_seen !== ser_drv && k < 600) begin
            @(posedge sys_clk);
            k++;
         end
         chk("ser_irq_seen", ser_drv, ser_seen);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
